// File: include/oec_pkg.sv
// shared constants and types for the occurrence event counter
package oec_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int ADDR_W     = 20;
   localparam int DATA_W     = 16;
   localparam int REG_AW     = 4;
   localparam int COUNT_W    = 16;
   localparam int TB_W       = 16;

   // ----------------------------------------------------------------
   // register indices (word addresses on the register port)
   // ----------------------------------------------------------------
   localparam logic [REG_AW-1:0] REG_CTRL       = 4'h0;
   localparam logic [REG_AW-1:0] REG_AC1_LOW    = 4'h1;
   localparam logic [REG_AW-1:0] REG_AC1_HIGH   = 4'h2;
   localparam logic [REG_AW-1:0] REG_G2_FIRST   = 4'h3;
   localparam logic [REG_AW-1:0] REG_G2_SECOND  = 4'h4;
   localparam logic [REG_AW-1:0] REG_COUNT      = 4'h5;
   localparam logic [REG_AW-1:0] REG_STATUS     = 4'h6;
   localparam logic [REG_AW-1:0] REG_TRACE_IDX  = 4'h7;
   localparam logic [REG_AW-1:0] REG_TRACE_ADDR = 4'h8;
   localparam logic [REG_AW-1:0] REG_TRACE_DATA = 4'h9;
   localparam logic [REG_AW-1:0] REG_TRACE_CNT  = 4'ha;

   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int CTRL_MODE_BIT  = 0;  // 0 transition, 1 range
   localparam int CTRL_PULSE_BIT = 1;  // 1 count trigger pulses
   localparam int CTRL_RUN_BIT   = 2;  // 1 monitor bus cycles
   localparam int CTRL_CLEAR_BIT = 3;  // write 1 clears count
   localparam int CTRL_TB_LSB    = 16; // time base divide count
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [TB_W-1:0] TB_DIV_RESET = 16'h0000;

   // status register fields
   localparam int STAT_GROUP_BIT = 0;
   localparam int STAT_OVF_BIT   = 1;
   localparam int STAT_WPTR_LSB  = 8;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {
      OEC_MODE_TRANSITION = 1'b0,
      OEC_MODE_RANGE      = 1'b1
   } oec_mode_e;

   typedef enum logic [0:0] {
      OEC_GROUP_ONE = 1'b0,
      OEC_GROUP_TWO = 1'b1
   } oec_group_e;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } oec_bus_s;

   typedef struct packed {
      logic [ADDR_W-1:0]  addr;
      logic [DATA_W-1:0]  data;
      logic [COUNT_W-1:0] count;
   } oec_trace_s;

endpackage

// File: rtl/oec_stamp_counter.sv
// time stamp counter with trigger pulse and time base sources
`timescale 1ns/1ps
module oec_stamp_counter #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // count sources
   input  wire logic             pulse_mode,
   input  wire logic             tb_tick,
   input  wire logic             trigger,
   input  wire logic             clear,
   // state
   output logic [WIDTH-1:0]      count,
   output logic                  overflow
);
   import oec_pkg::*;

   logic             trigger_prev;
   logic             next_trigger_prev;
   logic [WIDTH-1:0] next_count;
   logic             next_overflow;
   logic             incr;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   // the clear does not swallow an increment landing in the same cycle
   always_comb begin
      next_trigger_prev = trigger;
      incr = pulse_mode ? (trigger & ~trigger_prev)
                        : tb_tick;
      next_count    = count;
      next_overflow = overflow;
      if (clear) begin
         next_count    = incr ? {{(WIDTH-1){1'b0}}, 1'b1} : '0;
         next_overflow = 1'b0;
      end else if (incr) begin
         next_count = count + 1'b1;
      end
      if (incr && !clear && (&count)) begin
         next_overflow = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         trigger_prev <= 1'b0;
         count        <= '0;
         overflow     <= 1'b0;
      end else begin
         trigger_prev <= next_trigger_prev;
         count        <= next_count;
         overflow     <= next_overflow;
      end
   end

endmodule

// File: rtl/oec_top.sv
// occurrence event counter: sequencer, trace memory and register port
//
// Operation
// - in pulse-counting setting the count rises once per trigger rising edge.
// - in pulse-counting setting the time base tick has no effect.
// - the trigger that counts is the sequencer's own, not an outside pin.
// - transition mode, group one, comparator one hit moves to group two.
// - in group two a first comparator hit issues one trigger pulse.
// - in group two a second comparator hit traces the cycle and goes to group one.
// - transition mode traces only the cycles the sequencer picks.
// - range mode raises the trigger for each cycle inside the bounds.
// - range mode traces every cycle with the count of that moment.
// - an overflow flag is set when the count passes its maximum.
`timescale 1ns/1ps
module oec_top #(
   parameter int TRACE_DEPTH = 64,
   parameter int PTR_W       = 6
) (
   // clock and reset
   input  wire logic                     CLK,
   input  wire logic                     RST,
   // observed target bus cycles
   input  wire logic                     BUS_VALID,
   input  wire oec_pkg::oec_bus_s        BUS_CYCLE,
   // register port
   input  wire logic [oec_pkg::REG_AW-1:0] REG_ADDR,
   input  wire logic [31:0]              REG_WDATA,
   input  wire logic                     REG_WR,
   input  wire logic                     REG_RD,
   output logic [31:0]                   REG_RDATA,
   // status pins
   output logic                          EVENT_TRIGGER_PULSE,
   output logic                          OVERFLOW
);
   import oec_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [31:0]         ctrl;
   logic [31:0]         next_ctrl;
   logic [ADDR_W-1:0]   ac1_low;
   logic [ADDR_W-1:0]   ac1_high;
   logic [ADDR_W-1:0]   g2_first;
   logic [ADDR_W-1:0]   g2_second;
   logic [ADDR_W-1:0]   next_ac1_low;
   logic [ADDR_W-1:0]   next_ac1_high;
   logic [ADDR_W-1:0]   next_g2_first;
   logic [ADDR_W-1:0]   next_g2_second;
   logic [PTR_W-1:0]    trace_idx;
   logic [PTR_W-1:0]    next_trace_idx;
   logic                clear;
   logic                next_clear;
   logic [31:0]         rdata;
   logic [31:0]         next_rdata;

   oec_group_e          group;
   oec_group_e          next_group;
   logic                trig;
   logic                next_trig;
   logic                cap1;
   logic                next_cap1;
   logic                cap2;
   oec_bus_s            cyc1;
   oec_bus_s            next_cyc1;
   oec_bus_s            cyc2;

   logic [TB_W-1:0]     tb_cnt;
   logic [TB_W-1:0]     next_tb_cnt;
   logic                tb_tick;

   logic [COUNT_W-1:0]  count;
   logic                overflow;

   oec_trace_s          trace_mem [TRACE_DEPTH];
   logic [PTR_W-1:0]    wptr;
   logic [PTR_W-1:0]    next_wptr;
   oec_trace_s          trace_rd;

   logic                mode_range;
   logic                hit_ac1;
   logic                hit_range;
   logic                hit_first;
   logic                hit_second;

   assign mode_range = ctrl[CTRL_MODE_BIT];

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   // clear is a one-cycle pulse so software never has to write it back
   always_comb begin
      next_ctrl      = ctrl;
      next_ac1_low   = ac1_low;
      next_ac1_high  = ac1_high;
      next_g2_first  = g2_first;
      next_g2_second = g2_second;
      next_trace_idx = trace_idx;
      next_clear     = 1'b0;
      if (REG_WR) begin
         unique case (REG_ADDR)
            REG_CTRL: begin
               next_ctrl = REG_WDATA;
               next_ctrl[CTRL_CLEAR_BIT] = 1'b0;
               next_clear = REG_WDATA[CTRL_CLEAR_BIT];
            end
            REG_AC1_LOW:   next_ac1_low   = REG_WDATA[ADDR_W-1:0];
            REG_AC1_HIGH:  next_ac1_high  = REG_WDATA[ADDR_W-1:0];
            REG_G2_FIRST:  next_g2_first  = REG_WDATA[ADDR_W-1:0];
            REG_G2_SECOND: next_g2_second = REG_WDATA[ADDR_W-1:0];
            REG_TRACE_IDX: next_trace_idx = REG_WDATA[PTR_W-1:0];
            default: ;                      // read-only or unmapped
         endcase
      end
   end

   // read data is shown only in the cycle after the read strobe
   always_comb begin
      trace_rd   = trace_mem[trace_idx];
      next_rdata = 32'h0000_0000;
      if (REG_RD) begin
         unique case (REG_ADDR)
            REG_CTRL:       next_rdata = ctrl;
            REG_AC1_LOW:    next_rdata[ADDR_W-1:0] = ac1_low;
            REG_AC1_HIGH:   next_rdata[ADDR_W-1:0] = ac1_high;
            REG_G2_FIRST:   next_rdata[ADDR_W-1:0] = g2_first;
            REG_G2_SECOND:  next_rdata[ADDR_W-1:0] = g2_second;
            REG_COUNT:      next_rdata[COUNT_W-1:0] = count;
            REG_STATUS: begin
               next_rdata[STAT_GROUP_BIT] = group;
               next_rdata[STAT_OVF_BIT]   = overflow;
               next_rdata[STAT_WPTR_LSB +: PTR_W] = wptr;
            end
            REG_TRACE_IDX:  next_rdata[PTR_W-1:0] = trace_idx;
            REG_TRACE_ADDR: next_rdata[ADDR_W-1:0] = trace_rd.addr;
            REG_TRACE_DATA: next_rdata[DATA_W-1:0] = trace_rd.data;
            REG_TRACE_CNT:  next_rdata[COUNT_W-1:0] = trace_rd.count;
            default:        next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         ctrl      <= CTRL_RESET;
         ac1_low   <= '0;
         ac1_high  <= '0;
         g2_first  <= '0;
         g2_second <= '0;
         trace_idx <= '0;
         clear     <= 1'b0;
         rdata     <= 32'h0000_0000;
      end else begin
         ctrl      <= next_ctrl;
         ac1_low   <= next_ac1_low;
         ac1_high  <= next_ac1_high;
         g2_first  <= next_g2_first;
         g2_second <= next_g2_second;
         trace_idx <= next_trace_idx;
         clear     <= next_clear;
         rdata     <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // time base divider
   // ----------------------------------------------------------------
   // a divide count of n gives one tick every n+1 clocks
   always_comb begin
      tb_tick     = (tb_cnt == ctrl[CTRL_TB_LSB +: TB_W]);
      next_tb_cnt = tb_tick ? TB_DIV_RESET : tb_cnt + 1'b1;
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         tb_cnt <= TB_DIV_RESET;
      end else begin
         tb_cnt <= next_tb_cnt;
      end
   end

   // ----------------------------------------------------------------
   // event sequencer
   // ----------------------------------------------------------------
   // comparator one is an exact match in transition mode, a range in
   // range mode; both hits in one cycle take effect together
   always_comb begin
      hit_ac1    = (BUS_CYCLE.addr == ac1_low);
      hit_range  = (BUS_CYCLE.addr >= ac1_low)
                 && (BUS_CYCLE.addr <= ac1_high);
      hit_first  = (BUS_CYCLE.addr == g2_first);
      hit_second = (BUS_CYCLE.addr == g2_second);
      next_group = group;
      next_trig  = 1'b0;
      next_cap1  = 1'b0;
      next_cyc1  = BUS_CYCLE;
      if (BUS_VALID && ctrl[CTRL_RUN_BIT]) begin
         if (mode_range) begin
            next_group = OEC_GROUP_ONE;
            next_trig  = hit_range;
            next_cap1  = 1'b1;
         end else begin
            unique case (group)
               OEC_GROUP_ONE: begin
                  if (hit_ac1) begin
                     next_group = OEC_GROUP_TWO;
                  end
               end
               OEC_GROUP_TWO: begin
                  next_trig = hit_first;
                  if (hit_second) begin
                     next_cap1  = 1'b1;
                     next_group = OEC_GROUP_ONE;
                  end
               end
            endcase
         end
      end
   end

   // the trigger is high one cycle per hit; hits in back-to-back cycles merge into one edge
   always_ff @(posedge CLK) begin
      if (RST) begin
         group <= OEC_GROUP_ONE;
         trig  <= 1'b0;
         cap1  <= 1'b0;
         cap2  <= 1'b0;
         cyc1  <= '0;
         cyc2  <= '0;
      end else begin
         group <= next_group;
         trig  <= next_trig;
         cap1  <= next_cap1;
         cap2  <= cap1;
         cyc1  <= next_cyc1;
         cyc2  <= cyc1;
      end
   end

   // ----------------------------------------------------------------
   // time stamp counter
   // ----------------------------------------------------------------
   oec_stamp_counter #(
      .WIDTH      (COUNT_W)
   ) u_counter (
      .clk        (CLK),
      .rst        (RST),
      .pulse_mode (ctrl[CTRL_PULSE_BIT]),
      .tb_tick    (tb_tick),
      .trigger    (trig),
      .clear      (clear),
      .count      (count),
      .overflow   (overflow)
   );

   // ----------------------------------------------------------------
   // trace memory
   // ----------------------------------------------------------------
   // written two cycles after the bus cycle so the stored count already
   // includes that cycle's own trigger; the buffer wraps, oldest lost
   always_comb begin
      next_wptr = cap2 ? wptr + 1'b1 : wptr;
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         wptr <= '0;
      end else begin
         wptr <= next_wptr;
      end
      if (cap2) begin
         trace_mem[wptr] <= '{addr: cyc2.addr, data: cyc2.data,
                              count: count};
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign REG_RDATA           = rdata;
   assign EVENT_TRIGGER_PULSE = trig;
   assign OVERFLOW            = overflow;

endmodule

// File: verification/oec_bus_src.sv
// partner model: target bus cycles as seen by the event monitor
`timescale 1ns/1ps
module oec_bus_src (
   // clock
   input  wire logic          CLK,
   // observed bus cycle
   output logic               valid,
   output oec_pkg::oec_bus_s  cyc
);
   import oec_pkg::*;

   // idle bus at time zero
   initial begin
      valid = 1'b0;
      cyc   = '0;
   end

   // one cycle per call, then one idle cycle so triggers stay apart
   task automatic drive(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
      @(posedge CLK);
      valid <= 1'b1;
      cyc   <= {a, d};
      @(posedge CLK);
      valid <= 1'b0;
      cyc   <= ~cyc;  // released bus shows the complement of the last cycle
   endtask
endmodule

// File: verification/oec_top_chk.sv
// assertion checker on the ports of the occurrence event counter
`timescale 1ns/1ps
module oec_top_chk (
   // clock and reset
   input wire logic                         CLK,
   input wire logic                         RST,
   // bus and register port
   input wire logic                         BUS_VALID,
   input wire oec_pkg::oec_bus_s            BUS_CYCLE,
   input wire logic [oec_pkg::REG_AW-1:0]   REG_ADDR,
   input wire logic [31:0]                  REG_WDATA,
   input wire logic                         REG_WR,
   input wire logic                         REG_RD,
   input wire logic [31:0]                  REG_RDATA,
   // status pins
   input wire logic                         EVENT_TRIGGER_PULSE,
   input wire logic                         OVERFLOW
);
   import oec_pkg::*;
   logic [2:0]        ctl;  // run, pulse, mode shadows
   logic [ADDR_W-1:0] lo, hi, g2f;
   logic              mon, inr, cw;
   assign mon = BUS_VALID && ctl[2];
   assign inr = BUS_CYCLE.addr >= lo && BUS_CYCLE.addr <= hi;
   assign cw  = REG_WR && REG_ADDR == REG_CTRL && REG_WDATA[CTRL_CLEAR_BIT];

   // shadow of the settings; writes land at the strobe edge
   always_ff @(posedge CLK) begin
      if (RST) begin
         ctl <= 3'h0;
         lo  <= '0;
         hi  <= '0;
         g2f <= '0;
      end else if (REG_WR) begin
         case (REG_ADDR)
            REG_CTRL:     ctl <= REG_WDATA[2:0];
            REG_AC1_LOW:  lo  <= REG_WDATA[ADDR_W-1:0];
            REG_AC1_HIGH: hi  <= REG_WDATA[ADDR_W-1:0];
            REG_G2_FIRST: g2f <= REG_WDATA[ADDR_W-1:0];
            default:      ;
         endcase
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   trig_cause_a: assert property (
      EVENT_TRIGGER_PULSE |-> $past(mon))
      else $error("trigger without a monitored cycle");
   run_gate_a: assert property (
      BUS_VALID && !ctl[2] |=> !EVENT_TRIGGER_PULSE)
      else $error("trigger while monitor stopped");
   range_hit_a: assert property (
      mon && ctl[0] && inr |=> EVENT_TRIGGER_PULSE)
      else $error("range hit gave no trigger");
   range_miss_a: assert property (
      mon && ctl[0] && !inr |=> !EVENT_TRIGGER_PULSE)
      else $error("trigger outside the range");
   trig_first_a: assert property (
      EVENT_TRIGGER_PULSE && !ctl[0] |-> $past(BUS_CYCLE.addr) == g2f)
      else $error("transition trigger not from first comparator");
   trig_single_a: assert property (
      EVENT_TRIGGER_PULSE && !BUS_VALID |=> !EVENT_TRIGGER_PULSE)
      else $error("trigger longer than one cycle");
   ovf_hold_a: assert property (
      OVERFLOW && !cw && !$past(cw) && !$past(cw, 2) |=> OVERFLOW)
      else $error("overflow dropped without clear");
   ovf_cause_a: assert property (
      $rose(OVERFLOW) |-> !ctl[1] || $past(EVENT_TRIGGER_PULSE)
                          || $past(EVENT_TRIGGER_PULSE, 2))
      else $error("overflow without an increment");

   // main scenarios reached
   cover property (mon && ctl[0] && inr);
   cover property (EVENT_TRIGGER_PULSE && !ctl[0]);
   cover property ($rose(OVERFLOW));
endmodule

bind oec_top oec_top_chk u_oec_top_chk (.CLK, .RST, .BUS_VALID, .BUS_CYCLE,
   .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
   .EVENT_TRIGGER_PULSE, .OVERFLOW);

// File: verification/test_oec_top.sv
// self-checking bench for the occurrence event counter
`timescale 1ns/1ps
module test_oec_top;
   import oec_pkg::*;
   logic              CLK = 1'b0, RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0;
   logic [REG_AW-1:0] REG_ADDR = '0;
   logic [31:0]       REG_WDATA = '0, REG_RDATA, rv;
   logic              BUS_VALID, EVENT_TRIGGER_PULSE, OVERFLOW;
   oec_bus_s          BUS_CYCLE;
   int                fail_count = 0, num_checks = 0;
   int                cnt = 0, grp = 0, tw = 0;  // model state
   int                ticks = 0;  // time base ticks since reset release
   bit                rmode = 1'b0;
   logic [ADDR_W-1:0] lo, hi, a1, g2f, g2s;
   oec_trace_s        trq[$];  // traced entries not yet read back

   always #25 CLK = ~CLK;

   // control resets to time base mode with divide 0, so the count runs
   // one step per clock until software picks the pulse setting
   always @(posedge CLK) ticks <= RST ? 0 : ticks + 1;

   oec_top u_oec_top (.CLK, .RST, .BUS_VALID, .BUS_CYCLE, .REG_ADDR,
      .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .EVENT_TRIGGER_PULSE,
      .OVERFLOW);
   oec_bus_src u_oec_bus_src (.CLK, .valid(BUS_VALID), .cyc(BUS_CYCLE));

   // ----------------------------------------------------------------
   // register port and compare helpers
   // ----------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         fail_count++;
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge CLK);
      REG_WR    <= 1'b1;
      REG_ADDR  <= a;
      REG_WDATA <= d;
      @(posedge CLK);
      REG_WR    <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rdc(input string n, input logic [3:0] a, input logic [31:0] e);
      @(posedge CLK);
      REG_RD   <= 1'b1;
      REG_ADDR <= a;
      @(posedge CLK);
      REG_RD   <= 1'b0;
      @(negedge CLK);
      chk(n, e, REG_RDATA);
   endtask

   // ----------------------------------------------------------------
   // model of the sequencer, stepped with each bus cycle
   // ----------------------------------------------------------------
   task automatic bus(input logic [ADDR_W-1:0] a);
      logic [DATA_W-1:0] d;
      d = DATA_W'($urandom);
      u_oec_bus_src.drive(a, d);
      if (rmode) begin
         if (a >= lo && a <= hi) cnt++;
         trq.push_back({a, d, COUNT_W'(cnt)});
         tw++;
      end else if (grp == 0) begin
         if (a == a1) grp = 1;
      end else begin
         if (a == g2f) cnt++;
         if (a == g2s) begin
            trq.push_back({a, d, COUNT_W'(cnt)});
            tw++;
            grp = 0;
         end
      end
   endtask
   task automatic state;
      repeat (2) @(posedge CLK);
      rdc("count", REG_COUNT, 32'(cnt));
      rdc("status", REG_STATUS, 32'(((tw % 64) << 8) | grp));
   endtask
   task automatic dump;
      int b;
      b = tw - trq.size();
      foreach (trq[k]) begin
         wr(REG_TRACE_IDX, 32'((b + k) % 64));
         rdc("trace addr", REG_TRACE_ADDR, 32'(trq[k].addr));
         rdc("trace data", REG_TRACE_DATA, 32'(trq[k].data));
         rdc("trace count", REG_TRACE_CNT, 32'(trq[k].count));
      end
      trq.delete();
   endtask
   task automatic results;
      if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'h3cca));
      repeat (12) @(posedge CLK);
      RST <= 1'b0;
      // reset values; read-only and unmapped writes are dropped
      wr(REG_COUNT, 32'hffff);
      wr(4'hb, 32'h1);
      for (int a = 0; a < 16; a++) begin
         rv = (a == 5) ? 32'(ticks + 1) : 32'h0; // count seen a clock later
         if (a < 8 || a > 10) rdc("reset reg", 4'(a), rv);
      end
      // transition mode: only start-a then start-b counts
      a1 = 20'h01100;
      g2f = 20'h02000;
      g2s = 20'h02008;
      wr(REG_AC1_LOW, 32'(a1));
      wr(REG_G2_FIRST, 32'(g2f));
      wr(REG_G2_SECOND, 32'(g2s));
      wr(REG_CTRL, 32'he);  // clear what the time base counted so far
      repeat (4) begin
         bus(g2f);
         bus(g2s);
         bus(a1);
         state;
         bus(a1);
         bus(20'h01234);
         bus(g2f);
         bus(g2s);
         state;
      end
      dump;
      // clear, then hold while the time base ticks every clock
      wr(REG_CTRL, 32'he);
      cnt = 0;
      repeat (20) @(posedge CLK);
      state;
      // stopped monitor ignores the bus
      wr(REG_CTRL, 32'h2);
      u_oec_bus_src.drive(a1, 16'h0);
      u_oec_bus_src.drive(g2f, 16'h0);
      state;
      // range mode with addresses on both sides of the bounds
      lo = 20'h02000;
      hi = 20'h02006;
      rmode = 1'b1;
      wr(REG_AC1_LOW, 32'(lo));
      wr(REG_AC1_HIGH, 32'(hi));
      wr(REG_CTRL, 32'hf);
      cnt = 0;
      repeat (16) bus(20'h01ffe + 20'(2 * ($urandom % 6)));
      state;
      dump;
      // time base count runs past all ones, then clear
      rmode = 1'b0;
      wr(REG_CTRL, 32'h0);
      for (int i = 0; i < 70000 && OVERFLOW !== 1'b1; i++) @(posedge CLK);
      chk("overflow", 32'h1, 32'(OVERFLOW));
      wr(REG_CTRL, 32'ha);
      cnt = 0;
      state;
      chk("overflow", 32'h0, 32'(OVERFLOW));
      results;
   end

   // watchdog: the overflow wait dominates the run
   initial begin
      repeat (90000) @(posedge CLK);
      fail_count++;
      results;
   end
endmodule
